/* core/host_bus_port.sv */
// Purpose: Asynchronous host register port with open-drain status outputs.
// Assumes: Host pins are synchronised; engine strobes are on ref_clk.
// Notes: An access is acted on once, at the chip select falling edge after synchronisation.
`timescale 1ns/10ps
module host_bus_port
   import host_port_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [1:0] reg_select,
   input wire logic rw_dir,
   input wire logic chip_sel_n,
   input wire logic [7:0] host_data_bus_in,
   output logic [7:0] host_data_bus_out,
   output logic host_data_bus_oe,
   input wire logic carrier_in,
   input wire logic modem_ready_in,
   input wire engine_evt_t engine_evt,
   output logic tx_enable,
   output logic rx_enable,
   output logic [7:0] mode_out,
   output logic [7:0] tx_holding_out,
   output logic tx_holding_valid,
   output logic tx_holding_free_n,
   output logic tx_holding_free_n_oe,
   output logic rx_char_avail_n,
   output logic rx_char_avail_n_oe,
   output logic tx_idle_or_line_change_n,
   output logic tx_idle_or_line_change_n_oe
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation.
   logic [13:0] pins_s;
   logic [1:0] sel_s;
   logic dir_s;
   logic cs_n_s;
   logic cs_act_s;
   logic [7:0] wdata_s;
   logic carrier_s;
   logic ready_s;
   logic cs_n_d_reg;
   logic [SYNC_SETTLE-1:0] mdm_init_reg;
   logic carrier_d_reg;
   logic ready_d_reg;
   host_access_t acc;

   pin_sync #(.W(14)) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d({reg_select, rw_dir, !chip_sel_n, host_data_bus_in, carrier_in, modem_ready_in}),
      .q(pins_s)
   );
   // Chip select crosses as an active-high flag, so the synchroniser's reset value reads as deselected.
   // Otherwise the first edges after reset would see a false select and drive the bus.
   assign {sel_s, dir_s, cs_act_s, wdata_s, carrier_s, ready_s} = pins_s;
   assign cs_n_s = !cs_act_s;

   // Lines are stable while chip select is low, so one strobe per cycle suffices. see (RL7)
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cs_n_d_reg <= 1'b1;
      end else begin
         cs_n_d_reg <= cs_n_s;
      end
   end
   assign acc.rd = cs_n_d_reg && !cs_n_s && !dir_s; // see (RL5) (RL6)
   assign acc.wr = cs_n_d_reg && !cs_n_s && dir_s; // see (RL5) (RL6)
   assign acc.sel = sel_s; // see (RL4)
   assign acc.wdata = wdata_s; // see (RL9)

   ////////////////////////////////////////////////////////////////////////////
   // Mode and command registers.
   logic [7:0] mode_reg;
   logic [7:0] command_reg;

   // Cleared on reset; nothing runs until software programs them. see (RL1) (RL2) (RL3)
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mode_reg <= MODE_RESET;
         command_reg <= COMMAND_RESET;
      end else if (acc.wr && acc.sel == SEL_MODE) begin
         mode_reg <= acc.wdata;
      end else if (acc.wr && acc.sel == SEL_COMMAND) begin
         command_reg <= acc.wdata;
      end
   end
   assign tx_enable = command_reg[CMD_TX_EN];
   assign rx_enable = command_reg[CMD_RX_EN];
   assign mode_out = mode_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Transmit holding register.
   logic [7:0] tx_holding_reg;
   logic tx_full_reg;
   logic tx_load;

   assign tx_load = acc.wr && acc.sel == SEL_DATA;

   // A host load beats an engine take in the same cycle. see (RL10)
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_holding_reg <= DATA_RESET;
         tx_full_reg <= 1'b0;
      end else if (tx_load) begin
         tx_holding_reg <= acc.wdata;
         tx_full_reg <= 1'b1;
      end else if (engine_evt.tx_taken) begin
         tx_full_reg <= 1'b0;
      end
   end
   assign tx_holding_out = tx_holding_reg;
   assign tx_holding_valid = tx_full_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Receive holding register.
   logic [7:0] rx_holding_reg;
   logic rx_avail_reg;
   logic [7:0] rx_mask;
   logic rx_read;

   assign rx_read = acc.rd && acc.sel == SEL_DATA;
   // Mask off bits beyond the programmed character length. see (RL17)
   assign rx_mask = 8'hff >> (LEN_8 - mode_reg[MODE_LEN_LSB +: 2]);

   // New character wins over a read in the same cycle. see (RL13) (RL14)
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rx_holding_reg <= DATA_RESET;
         rx_avail_reg <= 1'b0;
      end else if (!rx_enable) begin
         rx_avail_reg <= 1'b0;
      end else if (engine_evt.rx_load) begin
         rx_holding_reg <= engine_evt.rx_data & rx_mask; // see (RL17)
         rx_avail_reg <= 1'b1;
      end else if (rx_read) begin
         rx_avail_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Idle-or-line-change status.
   logic idle_change_reg;
   logic tx_empty_reg;
   logic line_change;

   // Previous modem levels. Detection waits until synchroniser and history hold real levels, so a
   // pin that sits high through reset raises no false change; a change in those first cycles is lost.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         carrier_d_reg <= 1'b0;
         ready_d_reg <= 1'b0;
         mdm_init_reg <= '0;
      end else begin
         carrier_d_reg <= carrier_s;
         ready_d_reg <= ready_s;
         mdm_init_reg <= {mdm_init_reg[SYNC_SETTLE-2:0], 1'b1};
      end
   end
   assign line_change = mdm_init_reg[SYNC_SETTLE-1] && (carrier_s != carrier_d_reg || ready_s != ready_d_reg);

   // Empty is a level kept until the host loads another character.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_empty_reg <= 1'b0;
      end else if (tx_load) begin
         tx_empty_reg <= 1'b0;
      end else if (engine_evt.tx_empty) begin
         tx_empty_reg <= 1'b1;
      end
   end

   // Set wins over a clearing status read; a read cannot clear while empty. see (RL15) (RL16)
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         idle_change_reg <= 1'b0;
      end else if (line_change || (engine_evt.tx_empty && !tx_load)) begin
         idle_change_reg <= 1'b1;
      end else if (tx_load && !line_change) begin
         idle_change_reg <= 1'b0;
      end else if (acc.rd && acc.sel == SEL_STATUS && !tx_empty_reg) begin
         idle_change_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status word and read path.
   logic [7:0] status;
   logic [7:0] rdata;
   logic [7:0] rdata_reg;

   always_comb begin
      status = 8'h00;
      status[BIT_TX_FREE] = tx_enable && !tx_full_reg;
      status[BIT_RX_AVAIL] = rx_avail_reg;
      status[BIT_TX_IDLE_CHANGE] = idle_change_reg;
      status[BIT_CARRIER] = !carrier_s;
      status[BIT_READY] = !ready_s;
   end

   always_comb begin
      unique case (sel_s)
         SEL_DATA: rdata = rx_holding_reg;
         SEL_STATUS: rdata = status;
         SEL_MODE: rdata = mode_reg;
         SEL_COMMAND: rdata = command_reg;
      endcase
   end

   // Read data registered; driven only in a selected read. see (RL8) (RL18)
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_reg <= 8'h00;
         host_data_bus_oe <= 1'b0;
      end else begin
         rdata_reg <= rdata;
         host_data_bus_oe <= !cs_n_s && !dir_s;
      end
   end
   assign host_data_bus_out = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Open-drain status outputs: pin is driven low while enable is high.
   // Transmit-free is held released (enable low) while the transmitter is off. see (RL11)
   assign tx_holding_free_n = 1'b0;
   assign tx_holding_free_n_oe = status[BIT_TX_FREE]; // see (RL10) (RL12)
   assign rx_char_avail_n = 1'b0;
   assign rx_char_avail_n_oe = status[BIT_RX_AVAIL]; // see (RL13) (RL12)
   assign tx_idle_or_line_change_n = 1'b0;
   assign tx_idle_or_line_change_n_oe = status[BIT_TX_IDLE_CHANGE]; // see (RL15) (RL12)
endmodule : host_bus_port

/* core/host_port_pkg.sv */
// Purpose: Shared constants and carrier types for the host bus port and status outputs.
// Assumes: One 200 MHz clock, synchronous active-high reset on that clock.
// Notes: Register select codes are this port's own map of the four internal registers.
// Notes on behaviour
// (RL1) A high reset input performs a master reset.
// (RL2) Reset stops all activity and clears mode, command and status registers.
// (RL3) After reset the port stays idle until control words are written.
// (RL4) Two register-select inputs pick the register accessed in a bus cycle.
// (RL5) Direction low means read from device, high means write into device.
// (RL6) With chip select low the selected access is carried out.
// (RL7) Host keeps control, select and data valid while chip select is low.
// (RL8) With chip select high the data bus drivers are off.
// (RL9) Data bus is 8 bits, bit 0 least significant.
// (RL10) Transmit-free output is inverse of status bit zero.
// (RL11) Transmit-free output is meaningful only while the transmitter is enabled.
// (RL12) The three status outputs are open-drain and active low.
// (RL13) Receive-available output is inverse of status bit one.
// (RL14) Receive-available clears on holding register read and when receiver disabled.
// (RL15) Idle-or-change output is inverse of status bit two; set on idle or line change.
// (RL16) Status read releases idle-or-change only when the transmitter is not empty.
// (RL17) Short received characters are zero-filled in the high-order bits.
// (RL18) Read data is driven only during a chip-selected read.
package host_port_pkg;
   localparam int DATA_W = 8;
   localparam logic [1:0] SEL_DATA = 2'h0;
   localparam logic [1:0] SEL_STATUS = 2'h1;
   localparam logic [1:0] SEL_MODE = 2'h2;
   localparam logic [1:0] SEL_COMMAND = 2'h3;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] COMMAND_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam int BIT_TX_FREE = 0;
   localparam int BIT_RX_AVAIL = 1;
   localparam int BIT_TX_IDLE_CHANGE = 2;
   localparam int BIT_CARRIER = 6;
   localparam int BIT_READY = 7;
   localparam int CMD_TX_EN = 0;
   localparam int CMD_RX_EN = 2;
   localparam int MODE_LEN_LSB = 2;
   localparam logic [1:0] LEN_8 = 2'h3;
   // Cycles after reset until both modem synchroniser stages and the history flop hold real pin levels.
   localparam int SYNC_SETTLE = 3;

   // Bus cycle decoded from the host pins.
   typedef struct packed {
      logic rd;
      logic wr;
      logic [1:0] sel;
      logic [7:0] wdata;
   } host_access_t;

   // Event strobes from the serial engine.
   typedef struct packed {
      logic tx_taken;
      logic tx_empty;
      logic rx_load;
      logic [7:0] rx_data;
   } engine_evt_t;
endpackage : host_port_pkg

/* core/pin_sync.sv */
// Purpose: Two-flop synchroniser for a vector of asynchronous pins.
// Assumes: Inputs come from outside the ref_clk domain.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // Two stages give metastability time to settle before use.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : pin_sync

/* tb/host_bus_port_monitor.sv */
// Purpose: Checks the host port pins over time.
// Assumes: Bound into host_bus_port, one clock.
// Notes: Open-drain outputs are judged by their enables.
`timescale 1ns/10ps
module host_bus_port_monitor
   import host_port_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic rw_dir,
   input wire logic chip_sel_n,
   input wire logic host_data_bus_oe,
   input wire logic carrier_in,
   input wire engine_evt_t engine_evt,
   input wire logic tx_enable,
   input wire logic rx_enable,
   input wire logic [7:0] mode_out,
   input wire logic tx_holding_free_n_oe,
   input wire logic rx_char_avail_n_oe,
   input wire logic tx_idle_or_line_change_n_oe
);
   // Every check runs on the port clock and is quiet during reset.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   chk_reset_clears: assert property ($fell(rst) |-> !tx_enable && !rx_enable && mode_out == 8'h00)
      else $error("state left after reset");
   chk_bus_released: assert property (chip_sel_n [*4] |-> !host_data_bus_oe)
      else $error("bus driven while deselected");
   chk_drive_on_read: assert property ($rose(host_data_bus_oe) |-> !$past(chip_sel_n, 2) && !$past(rw_dir, 3))
      else $error("bus driven outside a read");
   chk_free_gated: assert property (!tx_enable [*2] |-> !tx_holding_free_n_oe)
      else $error("free asserted with transmitter off");
   chk_rx_sets: assert property (engine_evt.rx_load && rx_enable |-> ##[1:2] rx_char_avail_n_oe)
      else $error("receive flag not raised");
   chk_rx_off: assert property (!rx_enable [*2] |-> !rx_char_avail_n_oe)
      else $error("receive flag with receiver off");
   chk_idle_sets: assert property (engine_evt.tx_empty |-> ##[1:2] tx_idle_or_line_change_n_oe)
      else $error("idle flag not raised");
   chk_line_change: assert property ($changed(carrier_in) |-> ##[1:5] tx_idle_or_line_change_n_oe)
      else $error("line change not flagged");
endmodule : host_bus_port_monitor
bind host_bus_port host_bus_port_monitor u_mon (
   .ref_clk(ref_clk), .rst(rst), .rw_dir(rw_dir), .chip_sel_n(chip_sel_n),
   .host_data_bus_oe(host_data_bus_oe), .carrier_in(carrier_in), .engine_evt(engine_evt),
   .tx_enable(tx_enable), .rx_enable(rx_enable), .mode_out(mode_out),
   .tx_holding_free_n_oe(tx_holding_free_n_oe), .rx_char_avail_n_oe(rx_char_avail_n_oe),
   .tx_idle_or_line_change_n_oe(tx_idle_or_line_change_n_oe)
);

/* tb/host_bus_port_tb.sv */
// Purpose: Self-checking bench for the host port.
// Assumes: Engine events are one-cycle pulses.
// Notes: Both modem pins are driven, so either one can raise a line change.
`timescale 1ns/10ps
module host_bus_port_tb import host_port_pkg::*;;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic carrier_in = 1'b0;
   logic modem_ready_in = 1'b0;
   logic rw_dir, chip_sel_n, oe, tx_enable, rx_enable, fr_n, fr_oe, rx_n, rx_oe, id_n, id_oe, tx_vld;
   logic [1:0] reg_select;
   logic [7:0] host_data_bus_in, rdata, tx_out, rd_val, mode_val;
   engine_evt_t engine_evt = '0;
   int bad_count = 0;
   int cmp_count = 0;
   always #2.5 ref_clk = ~ref_clk;
   host_bus_port u_dut (
      .ref_clk(ref_clk), .rst(rst), .reg_select(reg_select), .rw_dir(rw_dir),
      .chip_sel_n(chip_sel_n), .host_data_bus_in(host_data_bus_in), .host_data_bus_out(rdata),
      .host_data_bus_oe(oe), .carrier_in(carrier_in), .modem_ready_in(modem_ready_in), .engine_evt(engine_evt),
      .tx_enable(tx_enable), .rx_enable(rx_enable), .mode_out(mode_val), .tx_holding_out(tx_out),
      .tx_holding_valid(tx_vld), .tx_holding_free_n(fr_n), .tx_holding_free_n_oe(fr_oe),
      .rx_char_avail_n(rx_n), .rx_char_avail_n_oe(rx_oe),
      .tx_idle_or_line_change_n(id_n), .tx_idle_or_line_change_n_oe(id_oe));
   host_cpu_model u_cpu (
      .ref_clk(ref_clk), .host_data_bus_out(rdata), .host_data_bus_oe(oe), .chip_sel_n(chip_sel_n),
      .rw_dir(rw_dir), .reg_select(reg_select), .host_data_bus_in(host_data_bus_in));
   ////////////////////////////////////////////////////////////
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk8
   // A flag is widened so one compare serves bytes and flags.
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask : chk1
   task automatic pulse(input logic [10:0] e);
      @(negedge ref_clk);
      engine_evt = engine_evt_t'(e);
      @(negedge ref_clk);
      engine_evt = '0;
      repeat (4) @(negedge ref_clk);
   endtask : pulse
   task automatic give_verdict;
      if (bad_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict
   // A hang counts as a mismatch.
   initial begin
      repeat (3000) @(posedge ref_clk);
      bad_count++;
      give_verdict();
   end
   // Configure, then walk transmit, line change and receive cases.
   initial begin
      repeat (4) @(negedge ref_clk);
      rst = 1'b0;
      u_cpu.bus_rd(SEL_COMMAND, rd_val);
      chk8(rd_val, COMMAND_RESET);
      chk1(oe, 1'b0);
      chk8({5'h00, fr_oe, rx_oe, id_oe}, 8'h00);
      u_cpu.bus_wr(SEL_MODE, 8'h0c);
      u_cpu.bus_wr(SEL_COMMAND, 8'h05);
      u_cpu.bus_rd(SEL_MODE, rd_val);
      chk8(rd_val, 8'h0c);
      chk8(mode_val, 8'h0c);
      chk8({5'h00, tx_enable, rx_enable, fr_oe}, 8'h07);
      u_cpu.bus_wr(SEL_DATA, 8'ha5);
      chk8({tx_out[7:1], fr_oe}, 8'ha4);
      chk1(tx_vld, 1'b1);
      pulse(11'h400);
      chk1(fr_oe, 1'b1);
      chk1(tx_vld, 1'b0);
      pulse(11'h200);
      u_cpu.bus_rd(SEL_STATUS, rd_val);
      chk8({4'h0, rd_val[2:0], id_oe}, 8'h0b);
      u_cpu.bus_wr(SEL_DATA, 8'h5a);
      chk1(id_oe, 1'b0);
      @(negedge ref_clk) carrier_in = 1'b1;
      repeat (6) @(negedge ref_clk);
      chk1(id_oe, 1'b1);
      u_cpu.bus_rd(SEL_STATUS, rd_val);
      chk1(id_oe, 1'b0);
      @(negedge ref_clk) modem_ready_in = 1'b1;
      repeat (6) @(negedge ref_clk);
      chk1(id_oe, 1'b1);
      pulse(11'h13c);
      chk1(rx_oe, 1'b1);
      u_cpu.bus_rd(SEL_DATA, rd_val);
      chk8(rd_val, 8'h3c);
      chk1(rx_oe, 1'b0);
      u_cpu.bus_wr(SEL_MODE, 8'h00);
      pulse(11'h1ff);
      u_cpu.bus_rd(SEL_DATA, rd_val);
      chk8(rd_val, 8'h1f);
      pulse(11'h1ff);
      chk8({4'h0, fr_n, rx_n, id_n, rx_oe}, 8'h01);
      // A reset in mid-run must clear the flags and registers that are set at this point.
      @(negedge ref_clk) rst = 1'b1;
      repeat (4) @(negedge ref_clk);
      rst = 1'b0;
      u_cpu.bus_rd(SEL_COMMAND, rd_val);
      chk8(rd_val, COMMAND_RESET);
      chk8({5'h00, tx_vld, rx_oe, id_oe}, 8'h00);
      u_cpu.bus_wr(SEL_COMMAND, 8'h01);
      chk8({6'h00, fr_oe, id_oe}, 8'h02);
      u_cpu.bus_wr(SEL_COMMAND, 8'h00);
      chk8({6'h00, rx_oe, fr_oe}, 8'h00);
      give_verdict();
   end
endmodule : host_bus_port_tb

/* tb/host_cpu_model.sv */
// Purpose: Host processor model that runs bus cycles.
// Assumes: Pins change only at falling edges.
// Notes: Released data lines show the inverse of the last byte.
`timescale 1ns/10ps
module host_cpu_model (
   input wire logic ref_clk,
   input wire logic [7:0] host_data_bus_out,
   input wire logic host_data_bus_oe,
   output logic chip_sel_n,
   output logic rw_dir,
   output logic [1:0] reg_select,
   output logic [7:0] host_data_bus_in
);
   // Idle bus until the first cycle.
   initial begin
      chip_sel_n = 1'b1;
      rw_dir = 1'b0;
      reg_select = 2'h0;
      host_data_bus_in = 8'h00;
   end
   // Pins are set together and held while selected.
   task automatic start(input logic dir, input logic [1:0] sel, input logic [7:0] d);
      @(negedge ref_clk);
      rw_dir = dir;
      reg_select = sel;
      host_data_bus_in = d;
      chip_sel_n = 1'b0;
   endtask : start
   // A stale byte could hide a late write capture, so the lines are inverted.
   task automatic stop(input logic [7:0] d);
      @(negedge ref_clk);
      chip_sel_n = 1'b1;
      host_data_bus_in = ~d;
      repeat (5) @(negedge ref_clk);
   endtask : stop
   task automatic bus_wr(input logic [1:0] sel, input logic [7:0] d);
      start(1'b1, sel, d);
      repeat (4) @(posedge ref_clk);
      stop(d);
   endtask : bus_wr
   // Read data is taken at the first falling edge that shows the enable high, where both have settled.
   task automatic bus_rd(input logic [1:0] sel, output logic [7:0] d);
      start(1'b0, sel, 8'h00);
      for (int i = 0; i < 8 && host_data_bus_oe !== 1'b1; i++) @(negedge ref_clk);
      d = host_data_bus_out;
      stop(8'h00);
   endtask : bus_rd
endmodule : host_cpu_model
